// ===== hdl/dlfp_link.sv
// Purpose: Two-pin debug link slave with identity, unlock and Flash data registers
// Assumes: Link clock far slower than clock; Flash controller shares clock
// Notes:   Long low on the shared clock pin is taken as a system reset
// How it works
// - Address 0x00 reads fixed identity byte
// - Address 0x01 reads silicon revision byte
// - Unlock control register sits at 0x02
// - Codes 0x02 then 0x01 enable programming
// - Only system reset leaves programming mode
// - Flash data register sits at 0xBF
// - Command, address, data bytes pass through data
// - Decode 06 read, 07 write, 08/03 erase
// - Shared pin: long low means reset
// - Target select routes data reads and writes
// - Two pins: clock in, data both ways
`timescale 1ns/1ns
`default_nettype none

module dlfp_link import dlfp_pkg::*; #(
  parameter logic [7:0] DEVICE_IDENTITY  = 8'h5A,  // Arbitrary identity value
  parameter logic [7:0] SILICON_REVISION = 8'h00
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            debug_link_clock,
  input  wire logic            debug_link_data_in,
  output var  logic            debug_link_data_out,
  output var  logic            debug_link_data_oe,
  output var  logic            system_reset_req,
  output var  logic            flash_program_mode,
  output var  dlfp_flash_req_t flash_req,
  input  wire logic            flash_done,
  input  wire logic            flash_rvalid,
  input  wire logic [7:0]      flash_rdata
);

  logic [1:0]          pins_s;
  logic                link_clk_s;
  logic                data_bit;
  logic                clk_prev;
  logic                link_rise;
  logic                link_fall;
  dlfp_link_state_t    state;
  dlfp_link_state_t    next_state;
  logic [2:0]          cnt;
  logic [2:0]          next_cnt;
  logic [1:0]          ins;
  logic [1:0]          next_ins;
  logic [7:0]          shift;
  logic [7:0]          next_shift;
  logic [7:0]          out_shift;
  logic [7:0]          next_out_shift;
  logic [7:0]          link_target_select;
  logic [7:0]          next_target;
  logic                next_oe;
  logic                next_dout;
  logic                wr_data;
  logic [7:0]          wr_byte;
  logic [7:0]          read_mux;
  logic [DLFP_LOW_W-1:0] low_cnt;
  logic [DLFP_LOW_W-1:0] next_low_cnt;
  logic                next_pin_reset;
  dlfp_unlock_state_t  ustate;
  dlfp_unlock_state_t  next_ustate;
  logic [7:0]          flash_program_unlock;
  logic [7:0]          next_unlock;
  logic [7:0]          flash_program_data;
  logic [7:0]          next_fdata;
  logic                cmd_open;
  logic                next_cmd_open;
  dlfp_flash_req_t     next_req;
  logic                wr_unlock;
  logic                wr_fdata;
  dlfp_cmd_t           decoded;

  generate
    if (DLFP_RESET_CYC_INT < 2 || DLFP_RESET_CYC_INT >= (1 << DLFP_LOW_W)) begin : g_bad_reset
      $error("dlfp_link reset low count does not fit its counter");
    end
  endgenerate

  dlfp_sync #(
    .WIDTH (2)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({~debug_link_clock, debug_link_data_in}),
    .q     (pins_s)
  );

  // Clock pin synced inverted so the flushed synchroniser reads as idle high
  assign link_clk_s = ~pins_s[1];
  assign data_bit   = pins_s[0];
  assign link_rise  = link_clk_s & ~clk_prev;
  assign link_fall  = ~link_clk_s & clk_prev;

  // Shared pin: a low held past the reset time is a reset request
  always_comb begin
    next_low_cnt = low_cnt;
    if (link_clk_s) begin
      next_low_cnt = '0;
    end else if (low_cnt != DLFP_RESET_CYC) begin
      next_low_cnt = low_cnt + 1'b1;
    end
    next_pin_reset = (next_low_cnt == DLFP_RESET_CYC);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      low_cnt          <= '0;
      system_reset_req <= 1'b0;
      clk_prev         <= 1'b1;
    end else begin
      low_cnt          <= next_low_cnt;
      system_reset_req <= next_pin_reset;
      clk_prev         <= link_clk_s;
    end
  end

  always_comb begin
    unique case (link_target_select)
      DLFP_ADDR_IDENTITY: read_mux = DEVICE_IDENTITY;
      DLFP_ADDR_REVISION: read_mux = SILICON_REVISION;
      DLFP_ADDR_UNLOCK:   read_mux = flash_program_unlock;
      DLFP_ADDR_DATA:     read_mux = flash_program_data;
      default:            read_mux = 8'h00;
    endcase
  end

  // Link framing: sample on rising edge, drive after falling edge
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_ins       = ins;
    next_shift     = shift;
    next_out_shift = out_shift;
    next_target    = link_target_select;
    next_oe        = debug_link_data_oe;
    next_dout      = debug_link_data_out;
    wr_data        = 1'b0;
    wr_byte        = {data_bit, shift[7:1]};
    if (link_fall) begin
      next_oe   = (state == DLFP_L_WAIT) || (state == DLFP_L_DATA_OUT);
      next_dout = (state == DLFP_L_WAIT) ? 1'b1 : out_shift[0];
    end
    if (link_rise) begin
      unique case (state)
        DLFP_L_IDLE: begin
          next_state = DLFP_L_INS;
          next_cnt   = '0;
        end
        DLFP_L_INS: begin
          next_ins = {data_bit, ins[1]};
          next_cnt = cnt + 1'b1;
          if (cnt == DLFP_INS_LAST) begin
            next_cnt = '0;
            if (next_ins == DLFP_INS_ADDR_READ) begin
              next_out_shift = link_target_select;
              next_state     = DLFP_L_DATA_OUT;
            end else if (next_ins == DLFP_INS_DATA_READ) begin
              next_state = DLFP_L_WAIT;
            end else begin
              next_state = DLFP_L_DATA_IN;
            end
          end
        end
        DLFP_L_DATA_IN: begin
          next_shift = wr_byte;
          next_cnt   = cnt + 1'b1;
          if (cnt == DLFP_LAST_BIT) begin
            if (ins == DLFP_INS_ADDR_WRITE) begin
              next_target = wr_byte;
              next_state  = DLFP_L_STOP;
            end else begin
              wr_data    = 1'b1;
              next_state = DLFP_L_WAIT;
            end
          end
        end
        DLFP_L_WAIT: begin
          next_cnt = '0;
          if (ins == DLFP_INS_DATA_READ) begin
            next_out_shift = read_mux;
            next_state     = DLFP_L_DATA_OUT;
          end else begin
            next_state = DLFP_L_STOP;
          end
        end
        DLFP_L_DATA_OUT: begin
          next_out_shift = {1'b0, out_shift[7:1]};
          next_cnt       = cnt + 1'b1;
          if (cnt == DLFP_LAST_BIT) begin
            next_state = DLFP_L_STOP;
          end
        end
        DLFP_L_STOP: begin
          next_state = DLFP_L_IDLE;
        end
        default: begin
          next_state = DLFP_L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || system_reset_req) begin
      state               <= DLFP_L_IDLE;
      cnt                 <= '0;
      ins                 <= '0;
      shift               <= '0;
      out_shift           <= '0;
      link_target_select  <= DLFP_TARGET_RESET;
      debug_link_data_oe  <= 1'b0;
      debug_link_data_out <= 1'b0;
    end else begin
      state               <= next_state;
      cnt                 <= next_cnt;
      ins                 <= next_ins;
      shift               <= next_shift;
      out_shift           <= next_out_shift;
      link_target_select  <= next_target;
      debug_link_data_oe  <= next_oe;
      debug_link_data_out <= next_dout;
    end
  end

  assign wr_unlock = wr_data && (link_target_select == DLFP_ADDR_UNLOCK);
  assign wr_fdata  = wr_data && (link_target_select == DLFP_ADDR_DATA);

  always_comb begin
    unique case (wr_byte)
      DLFP_CODE_READ:         decoded = DLFP_CMD_READ;
      DLFP_CODE_WRITE:        decoded = DLFP_CMD_WRITE;
      DLFP_CODE_PAGE_ERASE:   decoded = DLFP_CMD_PAGE_ERASE;
      DLFP_CODE_DEVICE_ERASE: decoded = DLFP_CMD_DEVICE_ERASE;
      default:                decoded = DLFP_CMD_NONE;
    endcase
  end

  // Unlock sequence and Flash byte stream
  always_comb begin
    next_ustate   = ustate;
    next_unlock   = flash_program_unlock;
    next_fdata    = flash_program_data;
    next_cmd_open = cmd_open;
    next_req      = '0;
    if (wr_unlock) begin
      next_unlock = wr_byte;
      unique case (ustate)
        DLFP_U_LOCKED: begin
          next_ustate = (wr_byte == DLFP_UNLOCK_FIRST) ? DLFP_U_HALF : DLFP_U_LOCKED;
        end
        DLFP_U_HALF: begin
          next_ustate = (wr_byte == DLFP_UNLOCK_SECOND) ? DLFP_U_ENABLED : DLFP_U_LOCKED;
        end
        DLFP_U_ENABLED: begin
          next_ustate = DLFP_U_ENABLED;
        end
        default: begin
          next_ustate = DLFP_U_LOCKED;
        end
      endcase
    end
    if (flash_done) begin
      next_cmd_open = 1'b0;
    end
    if (flash_rvalid) begin
      next_fdata = flash_rdata;
    end
    if (wr_fdata) begin
      next_fdata = wr_byte;
      if (ustate == DLFP_U_ENABLED) begin
        if (cmd_open) begin
          next_req.valid = 1'b1;
          next_req.cmd   = DLFP_CMD_NONE;
          next_req.data  = wr_byte;
          next_cmd_open  = 1'b1;
        end else if (decoded != DLFP_CMD_NONE) begin
          next_req.valid = 1'b1;
          next_req.first = 1'b1;
          next_req.cmd   = decoded;
          next_req.data  = wr_byte;
          next_cmd_open  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || system_reset_req) begin
      ustate               <= DLFP_U_LOCKED;
      flash_program_unlock <= DLFP_UNLOCK_RESET;
      flash_program_data   <= DLFP_DATA_RESET;
      cmd_open             <= 1'b0;
      flash_req            <= '0;
      flash_program_mode   <= 1'b0;
    end else begin
      ustate               <= next_ustate;
      flash_program_unlock <= next_unlock;
      flash_program_data   <= next_fdata;
      cmd_open             <= next_cmd_open;
      flash_req            <= next_req;
      flash_program_mode   <= (next_ustate == DLFP_U_ENABLED);
    end
  end

  // Checks
  a_unlock_pair: assert property (@(posedge clock) disable iff (rst)
    (wr_unlock && ustate == DLFP_U_HALF && wr_byte == DLFP_UNLOCK_SECOND && !system_reset_req)
    |=> ##1 flash_program_mode)
    else $error("ordered unlock pair did not enable programming");

  a_unlock_order: assert property (@(posedge clock) disable iff (rst)
    (ustate == DLFP_U_LOCKED) |=> (ustate != DLFP_U_ENABLED))
    else $error("programming enabled without first code");

  a_mode_sticky: assert property (@(posedge clock) disable iff (rst)
    (flash_program_mode && !system_reset_req) |=> flash_program_mode)
    else $error("programming mode left without reset");

  a_bad_code_clear: assert property (@(posedge clock) disable iff (rst)
    (wr_unlock && ustate == DLFP_U_HALF && wr_byte != DLFP_UNLOCK_SECOND && !system_reset_req)
    |=> (ustate == DLFP_U_LOCKED))
    else $error("broken unlock order kept progress");

  a_locked_ignored: assert property (@(posedge clock) disable iff (rst)
    flash_req.valid |-> $past(ustate == DLFP_U_ENABLED))
    else $error("flash byte issued while locked");

  a_cmd_decode: assert property (@(posedge clock) disable iff (rst)
    (wr_fdata && ustate == DLFP_U_ENABLED && !cmd_open && wr_byte == DLFP_CODE_WRITE && !system_reset_req)
    |=> (flash_req.valid && flash_req.first && flash_req.cmd == DLFP_CMD_WRITE))
    else $error("write command not decoded");

  a_identity_read: assert property (@(posedge clock) disable iff (rst || system_reset_req)
    (link_rise && state == DLFP_L_WAIT && ins == DLFP_INS_DATA_READ && link_target_select == DLFP_ADDR_IDENTITY)
    |=> (out_shift == DEVICE_IDENTITY && state == DLFP_L_DATA_OUT))
    else $error("identity read returned wrong value");

  a_revision_read: assert property (@(posedge clock) disable iff (rst || system_reset_req)
    (link_rise && state == DLFP_L_WAIT && ins == DLFP_INS_DATA_READ && link_target_select == DLFP_ADDR_REVISION)
    |=> (out_shift == SILICON_REVISION))
    else $error("revision read returned wrong value");

  a_reset_detect: assert property (@(posedge clock) disable iff (rst)
    (!link_clk_s && low_cnt == DLFP_RESET_CYC - 12'h001) |=> system_reset_req)
    else $error("long low on clock pin not taken as reset");

  a_oe_phase: assert property (@(posedge clock) disable iff (rst)
    $rose(debug_link_data_oe) |-> $past(state == DLFP_L_WAIT || state == DLFP_L_DATA_OUT))
    else $error("data pin driven outside a read phase");

  c_enabled:    cover property (@(posedge clock) disable iff (rst) $rose(flash_program_mode));
  c_first_cmd:  cover property (@(posedge clock) disable iff (rst) flash_req.valid && flash_req.first);
  c_pin_reset:  cover property (@(posedge clock) disable iff (rst) $rose(system_reset_req));
  c_data_read:  cover property (@(posedge clock) disable iff (rst) $rose(debug_link_data_oe));

endmodule // dlfp_link

`default_nettype wire

// ===== hdl/dlfp_pkg.sv
// Purpose: Shared constants and types for the debug link Flash programming block
// Assumes: 125 MHz system clock
// Notes:   Identity value defaults live in the top module as parameters
`default_nettype none

package dlfp_pkg;

  // Link register addresses
  localparam logic [7:0] DLFP_ADDR_IDENTITY = 8'h00;
  localparam logic [7:0] DLFP_ADDR_REVISION = 8'h01;
  localparam logic [7:0] DLFP_ADDR_UNLOCK   = 8'h02;
  localparam logic [7:0] DLFP_ADDR_DATA     = 8'hBF;

  // Reset values
  localparam logic [7:0] DLFP_UNLOCK_RESET = 8'h00;
  localparam logic [7:0] DLFP_DATA_RESET   = 8'h00;
  localparam logic [7:0] DLFP_TARGET_RESET = 8'h00;

  // Unlock codes, in the order they must arrive
  localparam logic [7:0] DLFP_UNLOCK_FIRST  = 8'h02;
  localparam logic [7:0] DLFP_UNLOCK_SECOND = 8'h01;

  // Flash command codes
  localparam logic [7:0] DLFP_CODE_READ         = 8'h06;
  localparam logic [7:0] DLFP_CODE_WRITE        = 8'h07;
  localparam logic [7:0] DLFP_CODE_PAGE_ERASE   = 8'h08;
  localparam logic [7:0] DLFP_CODE_DEVICE_ERASE = 8'h03;

  // Link instruction codes, sent LSB first after the start bit
  localparam logic [1:0] DLFP_INS_DATA_READ  = 2'h0;
  localparam logic [1:0] DLFP_INS_ADDR_READ  = 2'h1;
  localparam logic [1:0] DLFP_INS_DATA_WRITE = 2'h2;
  localparam logic [1:0] DLFP_INS_ADDR_WRITE = 2'h3;

  // Reset detection on the shared clock pin
  localparam int          DLFP_CLK_PERIOD_NS = 8;
  localparam int          DLFP_RESET_LOW_NS  = 20000;
  localparam int          DLFP_RESET_CYC_INT = (DLFP_RESET_LOW_NS + DLFP_CLK_PERIOD_NS - 1) / DLFP_CLK_PERIOD_NS;
  localparam int          DLFP_LOW_W         = 12;
  localparam logic [11:0] DLFP_RESET_CYC     = 12'(DLFP_RESET_CYC_INT);

  localparam logic [2:0] DLFP_LAST_BIT = 3'h7;
  localparam logic [2:0] DLFP_INS_LAST = 3'h1;

  typedef enum logic [5:0] {
    DLFP_L_IDLE     = 6'h01,
    DLFP_L_INS      = 6'h02,
    DLFP_L_DATA_IN  = 6'h04,
    DLFP_L_WAIT     = 6'h08,
    DLFP_L_DATA_OUT = 6'h10,
    DLFP_L_STOP     = 6'h20
  } dlfp_link_state_t;

  typedef enum logic [2:0] {
    DLFP_U_LOCKED  = 3'h1,
    DLFP_U_HALF    = 3'h2,
    DLFP_U_ENABLED = 3'h4
  } dlfp_unlock_state_t;

  typedef enum logic [2:0] {
    DLFP_CMD_NONE         = 3'h0,
    DLFP_CMD_READ         = 3'h1,
    DLFP_CMD_WRITE        = 3'h2,
    DLFP_CMD_PAGE_ERASE   = 3'h3,
    DLFP_CMD_DEVICE_ERASE = 3'h4
  } dlfp_cmd_t;

  typedef struct packed {
    logic       valid;
    logic       first;
    dlfp_cmd_t  cmd;
    logic [7:0] data;
  } dlfp_flash_req_t;

endpackage

`default_nettype wire

// ===== hdl/dlfp_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are slow levels relative to clock
// Notes:   First stage is read only by the second
`timescale 1ns/1ns
`default_nettype none

module dlfp_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("dlfp_sync needs WIDTH of at least 1");
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // dlfp_sync

`default_nettype wire

// ===== bench/dlfp_prog_model.sv
// Purpose: Behavioural programmer on the far side of the two-pin link
// Assumes: Link clock period of 20 system clocks, idling high
// Notes:   An undriven data line toggles away from its last level
`timescale 1ns/1ns
`default_nettype none

module dlfp_prog_model import dlfp_pkg::*; (
  input  wire logic clock,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  output var  logic link_clock,
  output var  logic link_data
);
  logic drv_en;
  logic drv_val;
  logic last_lvl;

  initial begin
    link_clock = 1'b1;
    drv_en     = 1'b0;
    drv_val    = 1'b0;
    last_lvl   = 1'b0;
  end

  // Data pin level from both parties
  always_comb link_data = dev_oe ? dev_out : (drv_en ? drv_val : ~last_lvl);

  always @(posedge clock) begin
    last_lvl <= link_data;
  end

  // One link clock period; data set while low, sampled just before the rise
  task automatic bit_cyc(input logic en, input logic val, output logic seen);
    @(posedge clock);
    link_clock <= 1'b0;
    drv_en     <= en;
    drv_val    <= val;
    repeat (10) @(posedge clock);
    seen = link_data;
    link_clock <= 1'b1;
    repeat (9) @(posedge clock);
  endtask

  task automatic xfer(input logic [1:0] ins, input logic [7:0] wdata, output logic [7:0] rdata,
                      output logic ready);
    logic s;
    ready = 1'b1;
    rdata = 8'h00;
    bit_cyc(1'b1, 1'b0, s);
    bit_cyc(1'b1, ins[0], s);
    bit_cyc(1'b1, ins[1], s);
    if (ins[1]) begin
      for (int i = 0; i < 8; i++) begin
        bit_cyc(1'b1, wdata[i], s);
      end
    end
    if (ins == DLFP_INS_DATA_READ || ins == DLFP_INS_DATA_WRITE) begin
      bit_cyc(1'b0, 1'b0, ready);
    end
    if (!ins[1]) begin
      for (int i = 0; i < 8; i++) begin
        bit_cyc(1'b0, 1'b0, s);
        rdata[i] = s;
      end
    end
    bit_cyc(1'b0, 1'b0, s);
  endtask

  // Long low on the shared clock pin
  task automatic pin_reset(input int cycles);
    @(posedge clock);
    link_clock <= 1'b0;
    drv_en     <= 1'b0;
    repeat (cycles) @(posedge clock);
    link_clock <= 1'b1;
    repeat (20) @(posedge clock);
  endtask
endmodule // dlfp_prog_model

`default_nettype wire

// ===== bench/dlfp_link_tb_top.sv
// Purpose: Self-checking bench for the debug link programming registers
// Assumes: 125 MHz clock, link clock at 160 ns
// Notes:   Flash controller side is driven directly by the bench
`timescale 1ns/1ns
`default_nettype none

module dlfp_link_tb_top import dlfp_pkg::*; ;
  localparam logic [7:0] IDENT = 8'h3C; // Arbitrary identity value
  localparam logic [7:0] REV   = 8'h11;
  localparam logic [7:0] BAD_SEQ [4] = '{8'h01, 8'h02, 8'h02, 8'h01};
  localparam logic [7:0] CODES [4]   = '{DLFP_CODE_READ, DLFP_CODE_WRITE, DLFP_CODE_PAGE_ERASE,
                                         DLFP_CODE_DEVICE_ERASE};
  localparam dlfp_cmd_t  KINDS [4]   = '{DLFP_CMD_READ, DLFP_CMD_WRITE, DLFP_CMD_PAGE_ERASE,
                                         DLFP_CMD_DEVICE_ERASE};

  logic            clock;
  logic            rst;
  logic            link_clock;
  logic            link_data;
  logic            data_out;
  logic            data_oe;
  logic            sys_rst_req;
  logic            prog_mode;
  dlfp_flash_req_t flash_req;
  logic            flash_done;
  logic            flash_rvalid;
  logic [7:0]      flash_rdata;
  logic            saw_sysrst;
  int              bad_count;
  int              comparisons;
  dlfp_flash_req_t reqs[$];

  initial clock = 1'b0;
  always #4 clock = ~clock;

  dlfp_link #(.DEVICE_IDENTITY(IDENT), .SILICON_REVISION(REV)) DUT (
    .clock               (clock),
    .rst                 (rst),
    .debug_link_clock    (link_clock),
    .debug_link_data_in  (link_data),
    .debug_link_data_out (data_out),
    .debug_link_data_oe  (data_oe),
    .system_reset_req    (sys_rst_req),
    .flash_program_mode  (prog_mode),
    .flash_req           (flash_req),
    .flash_done          (flash_done),
    .flash_rvalid        (flash_rvalid),
    .flash_rdata         (flash_rdata)
  );

  dlfp_prog_model prog (
    .clock      (clock),
    .dev_out    (data_out),
    .dev_oe     (data_oe),
    .link_clock (link_clock),
    .link_data  (link_data)
  );

  // Collect one-cycle request pulses
  always @(posedge clock) begin
    if (flash_req.valid === 1'b1) begin
      reqs.push_back(flash_req);
    end
    if (sys_rst_req === 1'b1) begin
      saw_sysrst <= 1'b1;
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_req(input dlfp_flash_req_t exp);
    dlfp_flash_req_t got;
    got = '0;
    if (reqs.size() > 0) begin
      got = reqs.pop_front();
    end
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: flash request got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] val);
    logic [7:0] r;
    logic       rdy;
    prog.xfer(DLFP_INS_ADDR_WRITE, addr, r, rdy);
    prog.xfer(DLFP_INS_DATA_WRITE, val, r, rdy);
    check8({7'h00, rdy}, 8'h01, "write ready");
  endtask

  task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp, input string what);
    logic [7:0] r;
    logic       rdy;
    prog.xfer(DLFP_INS_ADDR_WRITE, addr, r, rdy);
    prog.xfer(DLFP_INS_DATA_READ, 8'h00, r, rdy);
    check8(r, exp, what);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    logic [7:0] r;
    logic       rdy;
    rst          = 1'b1;
    flash_done   = 1'b0;
    flash_rvalid = 1'b0;
    flash_rdata  = 8'h00;
    saw_sysrst   = 1'b0;
    bad_count    = 0;
    comparisons  = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check8({5'h00, sys_rst_req, prog_mode, data_oe}, 8'h00, "outputs after reset");
    prog.xfer(DLFP_INS_ADDR_READ, 8'h00, r, rdy);
    check8(r, DLFP_TARGET_RESET, "target select reset");
    reg_read(DLFP_ADDR_IDENTITY, IDENT, "identity");
    reg_read(DLFP_ADDR_REVISION, REV, "revision");
    reg_read(DLFP_ADDR_UNLOCK, DLFP_UNLOCK_RESET, "unlock reset");
    reg_read(DLFP_ADDR_DATA, DLFP_DATA_RESET, "data reset");
    reg_write(DLFP_ADDR_IDENTITY, 8'hFF);
    reg_read(DLFP_ADDR_IDENTITY, IDENT, "identity after write");
    reg_read(8'h55, 8'h00, "unmapped address");
    $display("test registers done");

    reg_write(DLFP_ADDR_DATA, DLFP_CODE_READ);
    reg_read(DLFP_ADDR_DATA, DLFP_CODE_READ, "data stored while locked");
    for (int i = 0; i < 4; i++) begin
      reg_write(DLFP_ADDR_UNLOCK, BAD_SEQ[i]);
    end
    check8({7'h00, prog_mode}, 8'h00, "mode after wrong order");
    check8(8'(reqs.size()), 8'h00, "requests while locked");
    reg_write(DLFP_ADDR_UNLOCK, DLFP_UNLOCK_FIRST);
    reg_write(DLFP_ADDR_UNLOCK, DLFP_UNLOCK_SECOND);
    check8({7'h00, prog_mode}, 8'h01, "mode after unlock");
    reg_read(DLFP_ADDR_UNLOCK, DLFP_UNLOCK_SECOND, "unlock readback");
    $display("test unlock done");

    for (int i = 0; i < 4; i++) begin
      reg_write(DLFP_ADDR_DATA, CODES[i]);
      check_req(dlfp_flash_req_t'{1'b1, 1'b1, KINDS[i], CODES[i]});
      reg_write(DLFP_ADDR_DATA, {6'h10, 2'(i)});
      check_req(dlfp_flash_req_t'{1'b1, 1'b0, DLFP_CMD_NONE, {6'h10, 2'(i)}});
      @(posedge clock);
      flash_done <= 1'b1;
      @(posedge clock);
      flash_done <= 1'b0;
    end
    @(posedge clock);
    flash_rvalid <= 1'b1;
    flash_rdata  <= 8'hA5;
    @(posedge clock);
    flash_rvalid <= 1'b0;
    reg_read(DLFP_ADDR_DATA, 8'hA5, "flash read data");
    $display("test commands done");

    reg_write(DLFP_ADDR_UNLOCK, 8'h00);
    repeat (500) @(posedge clock);
    check8({7'h00, prog_mode}, 8'h01, "mode stays enabled");
    check8({7'h00, saw_sysrst}, 8'h00, "no reset from link bits");
    prog.pin_reset(2600);
    check8({6'h00, saw_sysrst, sys_rst_req}, 8'h02, "pin reset seen and released");
    check8({7'h00, prog_mode}, 8'h00, "mode after system reset");
    prog.xfer(DLFP_INS_ADDR_READ, 8'h00, r, rdy);
    check8(r, DLFP_TARGET_RESET, "target after system reset");
    reg_read(DLFP_ADDR_UNLOCK, DLFP_UNLOCK_RESET, "unlock after system reset");
    $display("test pin reset done");
    end_of_test();
  end
endmodule // dlfp_link_tb_top

`default_nettype wire
